// ===== hw/lcdhi_dev.sv
`timescale 1ns/1ns
module lcdhi_dev
   import lcdhi_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire lcdhi_mode_e MODE,
   output logic RX_VALID,
   output logic RX_REG_SEL,
   output logic [7:0] RX_DATA,
   input wire logic BUSY,
   input wire logic [6:0] ADDR_CNT,
   input wire logic [7:0] RD_DATA,
   lcdhi_if.dev BUS
);

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ADDR = 2'b01,
      PH_CTRL = 2'b10,
      PH_DATA = 2'b11
   } lcdhi_ph_e;

   typedef struct packed {
      logic [2:0] en;
      logic [1:0] csn;
      logic [1:0] regsel;
      logic [1:0] rdsel;
      logic [7:0] dl0;
      logic [7:0] dl1;
      logic scl_d;
      logic sda_d;
      logic nib_hi;
      logic [3:0] hi_nib;
      logic [7:0] rd_word;
      logic [7:0] sh;
      logic [3:0] cnt;
      lcdhi_ph_e ph;
      logic co;
      logic rx_valid;
      logic rx_rs;
      logic [7:0] rx_data;
      logic [7:0] dout;
      logic [7:0] doe;
   } lcdhi_dev_s;

   lcdhi_dev_s q;
   lcdhi_dev_s next_q;

   always_comb begin
      logic e_rise;
      logic e_fall;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic [7:0] b;
      logic [7:0] w;
      next_q = q;
      next_q.rx_valid = 1'b0;
      // First stages feed only the second stages
      next_q.en = {q.en[1:0], BUS.enable};
      next_q.csn = {q.csn[0], BUS.chip_select_n};
      next_q.regsel = {q.regsel[0], BUS.register_select};
      next_q.rdsel = {q.rdsel[0], BUS.read_sel};
      next_q.dl0 = BUS.data_line;
      next_q.dl1 = q.dl0;
      next_q.scl_d = q.dl1[SCL_BIT];
      next_q.sda_d = q.dl1[SDA_BIT];
      e_rise = q.en[1] & ~q.en[2];
      e_fall = ~q.en[1] & q.en[2];
      scl_rise = q.dl1[SCL_BIT] & ~q.scl_d;
      scl_fall = ~q.dl1[SCL_BIT] & q.scl_d;
      start = q.dl1[SCL_BIT] & q.scl_d & q.sda_d & ~q.dl1[SDA_BIT];
      stop = q.dl1[SCL_BIT] & q.scl_d & ~q.sda_d & q.dl1[SDA_BIT];
      b = {q.sh[6:0], q.dl1[SDA_BIT]};
      w = q.rd_word;
      unique case (MODE)
         MODE_BYTE, MODE_NIBBLE: begin
            if (e_rise && q.rdsel[1]) begin
               // Word is frozen for both nibbles so they agree
               if (MODE == MODE_BYTE || q.nib_hi) begin
                  w = q.regsel[1] ? RD_DATA : {BUSY, ADDR_CNT};
               end
               next_q.rd_word = w;
               if (MODE == MODE_BYTE) begin
                  next_q.dout = w;
                  next_q.doe = BYTE_OE;
               end else begin
                  next_q.dout = q.nib_hi ? {w[7:4], 4'h0}
                                         : {w[3:0], 4'h0};
                  next_q.doe = NIB_OE;
               end
            end
            if (e_fall) begin
               next_q.doe = 8'h00;
               if (MODE == MODE_BYTE) begin
                  if (!q.rdsel[1]) begin
                     next_q.rx_data = q.dl1;
                     next_q.rx_rs = q.regsel[1];
                     next_q.rx_valid = 1'b1;
                  end
               end else begin
                  next_q.nib_hi = ~q.nib_hi;
                  if (!q.rdsel[1]) begin
                     if (q.nib_hi) begin
                        next_q.hi_nib = q.dl1[7:4];
                     end else begin
                        next_q.rx_data = {q.hi_nib, q.dl1[7:4]};
                        next_q.rx_rs = q.regsel[1];
                        next_q.rx_valid = 1'b1;
                     end
                  end
               end
            end
         end
         MODE_SERIAL: begin
            next_q.doe = 8'h00;
            if (q.csn[1]) begin
               next_q.cnt = 4'h0;
            end else if (scl_rise) begin
               next_q.sh = b;
               if (q.cnt == 4'h7) begin
                  next_q.cnt = 4'h0;
                  next_q.rx_data = b;
                  next_q.rx_rs = q.regsel[1];
                  next_q.rx_valid = 1'b1;
               end else begin
                  next_q.cnt = q.cnt + 4'h1;
               end
            end
         end
         MODE_I2C: begin
            if (start) begin
               next_q.ph = PH_ADDR;
               next_q.cnt = 4'h0;
               next_q.doe = 8'h00;
            end else if (stop) begin
               next_q.ph = PH_IDLE;
               next_q.doe = 8'h00;
            end else if (q.ph != PH_IDLE) begin
               if (scl_rise && q.cnt < 4'h8) begin
                  next_q.sh = b;
                  next_q.cnt = q.cnt + 4'h1;
                  if (q.cnt == 4'h7) begin
                     unique case (q.ph)
                        PH_ADDR: begin
                           // Wrong address or a read: silent till the next start
                           if (b[7:1] == I2C_ADDR && !b[0]) begin
                              next_q.ph = PH_CTRL;
                           end else begin
                              next_q.ph = PH_IDLE;
                           end
                        end
                        PH_CTRL: begin
                           next_q.co = b[7];
                           next_q.rx_rs = b[6];
                           next_q.ph = PH_DATA;
                        end
                        PH_DATA: begin
                           next_q.rx_data = b;
                           next_q.rx_valid = 1'b1;
                           next_q.ph = q.co ? PH_CTRL : PH_DATA;
                        end
                        PH_IDLE: begin
                           next_q.ph = PH_IDLE;
                        end
                     endcase
                  end
               end
               if (scl_fall && q.cnt == 4'h8) begin
                  next_q.cnt = 4'h9;
                  next_q.dout = 8'h00;
                  next_q.doe = ACK_OE;
               end
               if (scl_fall && q.cnt == 4'h9) begin
                  next_q.cnt = 4'h0;
                  next_q.doe = 8'h00;
               end
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         q <= '0;
         q.nib_hi <= NIB_HI_RST;
         q.csn <= 2'b11;
         // Lines idle high; a low start would fake a clock edge
         q.dl0 <= 8'hFF;
         q.dl1 <= 8'hFF;
         q.scl_d <= 1'b1;
         q.sda_d <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign RX_VALID = q.rx_valid;
   assign RX_REG_SEL = q.rx_rs;
   assign RX_DATA = q.rx_data;
   assign BUS.d_do = q.dout;
   assign BUS.d_oe = q.doe;

endmodule : lcdhi_dev

// ===== hw/lcdhi_host.sv
`timescale 1ns/1ns
module lcdhi_host
   import lcdhi_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire lcdhi_mode_e MODE,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_REG_SEL,
   input wire logic CMD_READ,
   input wire logic [7:0] CMD_DATA,
   output logic RSP_VALID,
   output logic [7:0] RSP_DATA,
   lcdhi_if.host BUS
);

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SETUP = 3'b001,
      H_EHI = 3'b010,
      H_ELO = 3'b011,
      H_BLO = 3'b100,
      H_BHI = 3'b101,
      H_START = 3'b110,
      H_STOP = 3'b111
   } lcdhi_hst_e;

   typedef struct packed {
      lcdhi_hst_e st;
      logic [8:0] tmr;
      logic nib;
      logic poll;
      logic regsel;
      logic rdsel;
      logic [7:0] dat;
      logic [7:0] sh;
      logic [3:0] bit_n;
      logic [1:0] byte_n;
      logic en;
      logic csn;
      logic scl;
      logic sda;
      logic [7:0] dl0;
      logic [7:0] dl1;
      logic [7:0] rd;
      logic rsp_valid;
      logic [7:0] dout;
      logic [7:0] oe;
   } lcdhi_host_s;

   lcdhi_host_s q;
   lcdhi_host_s next_q;

   function automatic logic [7:0] i2c_byte(input logic [1:0] idx,
                                           input logic regsel,
                                           input logic [7:0] dat);
      unique case (idx)
         2'd0: i2c_byte = {I2C_ADDR, 1'b0};
         2'd1: i2c_byte = {1'b0, regsel, 6'h00};
         default: i2c_byte = dat;
      endcase
   endfunction : i2c_byte

   function automatic logic [8:0] low_cnt(input lcdhi_mode_e m);
      low_cnt = (m == MODE_I2C) ? I2C_LO_CNT : SER_LO_CNT;
   endfunction : low_cnt

   always_comb begin
      logic par;
      par = (MODE == MODE_BYTE) || (MODE == MODE_NIBBLE);
      next_q = q;
      next_q.rsp_valid = 1'b0;
      next_q.dl0 = BUS.data_line;
      next_q.dl1 = q.dl0;
      if (q.tmr != 9'd0) begin
         next_q.tmr = q.tmr - 9'd1;
      end
      unique case (q.st)
         H_IDLE: begin
            if (CMD_VALID) begin
               next_q.regsel = CMD_REG_SEL;
               next_q.rdsel = CMD_READ & par;
               next_q.dat = CMD_DATA;
               next_q.nib = (MODE == MODE_NIBBLE);
               next_q.poll = 1'b0;
               next_q.bit_n = 4'h0;
               next_q.byte_n = 2'd0;
               if (par) begin
                  next_q.st = H_SETUP;
                  next_q.tmr = E_SU_CNT;
               end else if (MODE == MODE_SERIAL) begin
                  next_q.csn = 1'b0;
                  next_q.scl = 1'b0;
                  next_q.sh = CMD_DATA;
                  next_q.st = H_BLO;
                  next_q.tmr = SER_LO_CNT;
               end else begin
                  next_q.sda = 1'b0;
                  next_q.st = H_START;
                  next_q.tmr = I2C_SU_CNT;
               end
            end
         end
         H_SETUP: begin
            if (q.tmr == 9'd0) begin
               next_q.en = 1'b1;
               next_q.st = H_EHI;
               next_q.tmr = E_HI_CNT;
            end
         end
         H_EHI: begin
            if (q.tmr == 9'd0) begin
               next_q.en = 1'b0;
               if (MODE == MODE_BYTE) begin
                  next_q.rd = q.dl1;
               end else if (q.nib) begin
                  next_q.rd[7:4] = q.dl1[7:4];
               end else begin
                  next_q.rd[3:0] = q.dl1[7:4];
               end
               next_q.st = H_ELO;
               next_q.tmr = E_LO_CNT;
            end
         end
         H_ELO: begin
            if (q.tmr == 9'd0) begin
               next_q.st = H_IDLE;
               if (MODE == MODE_NIBBLE && q.nib) begin
                  // Low nibble goes out only after the hold time
                  next_q.nib = 1'b0;
                  next_q.st = H_SETUP;
                  next_q.tmr = E_SU_CNT;
               end else if (q.poll) begin
                  if (q.rd[7]) begin
                     next_q.nib = 1'b1;
                     next_q.st = H_SETUP;
                     next_q.tmr = E_SU_CNT;
                  end
               end else if (q.rdsel) begin
                  next_q.rsp_valid = 1'b1;
               end else if (MODE == MODE_NIBBLE && !q.regsel) begin
                  next_q.poll = 1'b1;
                  next_q.rdsel = 1'b1;
                  next_q.nib = 1'b1;
                  next_q.st = H_SETUP;
                  next_q.tmr = E_SU_CNT;
               end
            end
         end
         H_BLO: begin
            // Data moves mid-low so it never shifts next to an SCL edge
            if (q.tmr == (low_cnt(MODE) >> 1)) begin
               next_q.sda = (q.bit_n == 4'h8) ? 1'b1 : q.sh[7];
            end
            if (q.tmr == 9'd0) begin
               next_q.scl = 1'b1;
               next_q.st = H_BHI;
               next_q.tmr = (MODE == MODE_I2C) ? I2C_HI_CNT : SER_HI_CNT;
            end
         end
         H_BHI: begin
            if (q.tmr == 9'd0) begin
               next_q.scl = 1'b0;
               next_q.sh = {q.sh[6:0], 1'b0};
               next_q.bit_n = q.bit_n + 4'h1;
               next_q.st = H_BLO;
               next_q.tmr = low_cnt(MODE);
               if (MODE == MODE_SERIAL && q.bit_n == 4'h7) begin
                  next_q.csn = 1'b1;
                  next_q.st = H_IDLE;
               end else if (MODE == MODE_I2C && q.bit_n == 4'h8) begin
                  next_q.bit_n = 4'h0;
                  next_q.byte_n = q.byte_n + 2'd1;
                  next_q.sh = i2c_byte(q.byte_n + 2'd1, q.regsel, q.dat);
                  if (q.byte_n == 2'd2) begin
                     next_q.st = H_STOP;
                  end
               end
            end
         end
         H_START: begin
            if (q.tmr == 9'd0) begin
               next_q.scl = 1'b0;
               next_q.sh = i2c_byte(2'd0, q.regsel, q.dat);
               next_q.st = H_BLO;
               next_q.tmr = I2C_LO_CNT;
            end
         end
         H_STOP: begin
            if (q.bit_n == 4'h0 && q.tmr == (I2C_LO_CNT >> 1)) begin
               next_q.sda = 1'b0;
            end
            if (q.tmr == 9'd0) begin
               next_q.bit_n = q.bit_n + 4'h1;
               unique case (q.bit_n)
                  4'h0: begin
                     next_q.scl = 1'b1;
                     next_q.tmr = I2C_SU_CNT;
                  end
                  4'h1: begin
                     next_q.sda = 1'b1;
                     next_q.tmr = I2C_BUF_CNT;
                  end
                  default: begin
                     next_q.st = H_IDLE;
                  end
               endcase
            end
         end
      endcase
      unique case (MODE)
         MODE_BYTE: begin
            next_q.dout = next_q.dat;
            next_q.oe = (next_q.st != H_IDLE && !next_q.rdsel)
                        ? BYTE_OE : 8'h00;
         end
         MODE_NIBBLE: begin
            next_q.dout = next_q.nib ? {next_q.dat[7:4], 4'h0}
                                     : {next_q.dat[3:0], 4'h0};
            next_q.oe = (next_q.st != H_IDLE && !next_q.rdsel)
                        ? NIB_OE : 8'h00;
         end
         MODE_SERIAL: begin
            next_q.dout = {next_q.scl, next_q.sda, 6'h00};
            next_q.oe = SER_OE;
         end
         MODE_I2C: begin
            next_q.dout = 8'h00;
            next_q.oe = {~next_q.scl, ~next_q.sda, 6'h00};
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         q <= '0;
         q.csn <= 1'b1;
         q.scl <= 1'b1;
         q.sda <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign CMD_READY = (q.st == H_IDLE);
   assign RSP_VALID = q.rsp_valid;
   assign RSP_DATA = q.rd;
   assign BUS.enable = q.en;
   assign BUS.register_select = q.regsel;
   assign BUS.read_sel = q.rdsel;
   assign BUS.chip_select_n = q.csn;
   assign BUS.h_do = q.dout;
   assign BUS.h_oe = q.oe;

endmodule : lcdhi_host

// ===== hw/lcdhi_if.sv
`timescale 1ns/1ns
interface lcdhi_if;
   logic enable;
   logic register_select;
   logic read_sel;
   logic chip_select_n;
   logic [7:0] h_do;
   logic [7:0] h_oe;
   logic [7:0] d_do;
   logic [7:0] d_oe;
   logic [7:0] data_line;

   // Pulled up; a line is low if an enabled driver of either end drives it low
   assign data_line = (h_do | ~h_oe) & (d_do | ~d_oe);

   modport dev (
      input enable, register_select, read_sel, chip_select_n, data_line,
      output d_do, d_oe
   );
   modport host (
      output enable, register_select, read_sel, chip_select_n, h_do, h_oe,
      input data_line
   );
endinterface : lcdhi_if

// ===== hw/lcdhi_pkg.sv
package lcdhi_pkg;

   typedef enum logic [1:0] {
      MODE_BYTE = 2'b00,
      MODE_NIBBLE = 2'b01,
      MODE_SERIAL = 2'b10,
      MODE_I2C = 2'b11
   } lcdhi_mode_e;

   // Arbitrary 7-bit slave address
   localparam logic [6:0] I2C_ADDR = 7'h2A;
   localparam logic NIB_HI_RST = 1'b1;
   localparam logic [7:0] NIB_OE = 8'hF0;
   localparam logic [7:0] BYTE_OE = 8'hFF;
   localparam logic [7:0] SER_OE = 8'hC0;
   localparam logic [7:0] ACK_OE = 8'h40;
   localparam int SCL_BIT = 7;
   localparam int SDA_BIT = 6;

   localparam int SYS_CLK_NS = 4;
   localparam int E_SETUP_NS = 20;
   localparam int E_HIGH_NS = 200;
   localparam int E_CYCLE_NS = 400;
   localparam int SER_LOW_NS = 160;
   localparam int SER_CYCLE_NS = 200;
   localparam int I2C_LOW_NS = 1300;
   localparam int I2C_HIGH_NS = 600;
   localparam int I2C_SU_NS = 600;
   localparam int I2C_BUF_NS = 1300;

   localparam logic [8:0] E_SU_CNT =
      9'((E_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] E_HI_CNT =
      9'((E_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] E_LO_CNT =
      9'((E_CYCLE_NS - E_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] SER_LO_CNT =
      9'((SER_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] SER_HI_CNT =
      9'((SER_CYCLE_NS - SER_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] I2C_LO_CNT =
      9'((I2C_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] I2C_HI_CNT =
      9'((I2C_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] I2C_SU_CNT =
      9'((I2C_SU_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
   localparam logic [8:0] I2C_BUF_CNT =
      9'((I2C_BUF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

endpackage : lcdhi_pkg

// ===== verification/lcdhi_properties.sv
`timescale 1ns/1ns
module lcdhi_properties
   import lcdhi_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire lcdhi_mode_e MODE,
   input wire logic enable,
   input wire logic register_select,
   input wire logic read_sel,
   input wire logic chip_select_n,
   input wire logic [7:0] h_do,
   input wire logic [7:0] h_oe,
   input wire logic [7:0] d_do,
   input wire logic [7:0] d_oe,
   input wire logic [7:0] data_line
);
   typedef struct packed {
      logic clk_d;
      logic [3:0] rises;
   } lcdhi_chk_s;
   lcdhi_chk_s st;
   lcdhi_chk_s next_st;
   logic ser;
   logic par;
   assign ser = (MODE == MODE_SERIAL);
   assign par = (MODE == MODE_BYTE) || (MODE == MODE_NIBBLE);

   // Rising serial clocks within one chip-select frame
   always_comb begin
      next_st = st;
      next_st.clk_d = data_line[7];
      if (chip_select_n) begin
         next_st.rises = 4'h0;
      end else if (data_line[7] && !st.clk_d) begin
         next_st.rises = st.rises + 4'h1;
      end
   end
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   a_dev_nib_low: assert property (
      MODE == MODE_NIBBLE |-> d_oe[3:0] == 4'h0)
      else $error("device drives low lines in nibble mode");
   a_host_nib_low: assert property (
      MODE == MODE_NIBBLE |-> h_oe[3:0] == 4'h0)
      else $error("host drives low lines in nibble mode");
   a_dev_byte_oe: assert property (
      (MODE == MODE_BYTE && d_oe != 8'h00) |-> d_oe == BYTE_OE)
      else $error("byte read not on all eight lines");
   a_dev_nib_oe: assert property (
      (MODE == MODE_NIBBLE && d_oe != 8'h00) |-> d_oe == NIB_OE)
      else $error("nibble read on wrong lines");
   a_dev_oe_cause: assert property (
      (par && $rose(d_oe[7])) |-> enable && read_sel && $past(enable, 2))
      else $error("device drove lines without a read strobe");
   a_ser_dev_quiet: assert property (
      ser |-> d_oe == 8'h00)
      else $error("device drives lines in serial mode");
   a_i2c_dev_lines: assert property (
      MODE == MODE_I2C |-> (d_oe & ~ACK_OE) == 8'h00)
      else $error("device drives a line other than data in I2C");
   a_i2c_ack_low: assert property (
      (MODE == MODE_I2C && d_oe[6]) |-> !d_do[6])
      else $error("device acknowledge not driven low");
   a_cs_before_clk: assert property (
      (ser && $rose(data_line[7])) |->
         !chip_select_n && !$past(chip_select_n, 4))
      else $error("serial clock rose without prior select");
   a_ser_rs_held: assert property (
      (ser && !chip_select_n && !$past(chip_select_n)) |->
         $stable(register_select))
      else $error("register select changed within a byte");
   a_ser_data_set: assert property (
      (ser && $rose(data_line[7])) |-> $stable(data_line[6]))
      else $error("serial data moved at clock rise");
   a_ser_eight_clk: assert property (
      (ser && $rose(chip_select_n)) |-> st.rises == 4'h8)
      else $error("serial frame not eight clocks");
   a_wr_data_hold: assert property (
      (par && $fell(enable) && !read_sel) |=> $stable(h_do) [*3])
      else $error("write data not held after strobe fall");
endmodule : lcdhi_properties

// ===== verification/tb_lcd_controller_host_interface.sv
`timescale 1ns/1ns
module tb_lcd_controller_host_interface
   import lcdhi_pkg::*;
();
   logic sys_clk, rst_b, cmd_valid, cmd_ready, cmd_reg_sel, cmd_read;
   logic rsp_valid, busy, rx_valid_a, rx_rs_a, rx_valid_b, rx_rs_b;
   logic [7:0] cmd_data, rsp_data, rd_data, rx_data_a, rx_data_b;
   logic [7:0] rsp_last;
   logic [6:0] addr_cnt;
   lcdhi_mode_e mode;
   logic [8:0] qa[$];
   logic [8:0] qb[$];
   int num_errors = 0;
   int n_tests = 0;

   lcdhi_if bus_a ();
   lcdhi_if bus_b ();

   lcdhi_host i_lcdhi_host (.SYS_CLK(sys_clk), .RST_B(rst_b), .MODE(mode),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
      .CMD_REG_SEL(cmd_reg_sel), .CMD_READ(cmd_read),
      .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
      .BUS(bus_a));
   lcdhi_dev i_lcdhi_dev (.SYS_CLK(sys_clk), .RST_B(rst_b), .MODE(mode),
      .RX_VALID(rx_valid_a), .RX_REG_SEL(rx_rs_a), .RX_DATA(rx_data_a),
      .BUSY(busy), .ADDR_CNT(addr_cnt), .RD_DATA(rd_data), .BUS(bus_a));
   // Second device faces the bench, which breaks host rules on purpose
   lcdhi_dev i_lcdhi_dev_b (.SYS_CLK(sys_clk), .RST_B(rst_b), .MODE(mode),
      .RX_VALID(rx_valid_b), .RX_REG_SEL(rx_rs_b), .RX_DATA(rx_data_b),
      .BUSY(busy), .ADDR_CNT(addr_cnt), .RD_DATA(rd_data), .BUS(bus_b));
   lcdhi_properties i_lcdhi_properties (.SYS_CLK(sys_clk), .RST_B(rst_b),
      .MODE(mode), .enable(bus_a.enable),
      .register_select(bus_a.register_select), .read_sel(bus_a.read_sel),
      .chip_select_n(bus_a.chip_select_n), .h_do(bus_a.h_do),
      .h_oe(bus_a.h_oe), .d_do(bus_a.d_do), .d_oe(bus_a.d_oe),
      .data_line(bus_a.data_line));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (rx_valid_a === 1'b1) qa.push_back({rx_rs_a, rx_data_a});
      if (rx_valid_b === 1'b1) qb.push_back({rx_rs_b, rx_data_b});
      if (rsp_valid === 1'b1) rsp_last = rsp_data;
   end

   task wrap_up;
      if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   task chk(input string what, input logic [8:0] seen, logic [8:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         #1;
      end
   endtask : tick

   task automatic wait_ready(input int lim);
      for (int i = 0; i < lim && cmd_ready !== 1'b1; i++) tick(1);
      if (cmd_ready !== 1'b1) begin
         num_errors++;
         $display("[ERR] cmd_ready expected 1 seen %b", cmd_ready);
         wrap_up();
      end
   endtask : wait_ready

   task cmd_go(input logic rs, input logic rd, input logic [7:0] d);
      wait_ready(50);
      cmd_reg_sel = rs;
      cmd_read = rd;
      cmd_data = d;
      cmd_valid = 1'b1;
      tick(1);
      cmd_valid = 1'b0;
   endtask : cmd_go

   task cmd(input logic rs, input logic rd, input logic [7:0] d);
      cmd_go(rs, rd, d);
      wait_ready(20000);
   endtask : cmd

   task rd_chk(input logic rs, input logic [7:0] exp);
      rsp_last = 'x;
      cmd(rs, 1'b1, 8'h00);
      // Response pulse is latched at the edge after ready returns
      tick(1);
      chk("read word", {1'b0, rsp_last}, {1'b0, exp});
   endtask : rd_chk

   task automatic rx_chk(input bit b, input logic [8:0] exp);
      logic [8:0] v;
      v = 'x;
      if (b && qb.size() > 0) v = qb.pop_front();
      if (!b && qa.size() > 0) v = qa.pop_front();
      chk(b ? "rx b" : "rx a", v, exp);
   endtask : rx_chk

   task reset_to(input lcdhi_mode_e m);
      mode = m;
      rst_b = 1'b0;
      tick(4);
      rst_b = 1'b1;
      qa.delete();
      qb.delete();
   endtask : reset_to

   // Bench as nibble host: upper lines carry data, lower lines junk
   task b_nib(input logic [7:0] v);
      bus_b.h_do = v;
      bus_b.h_oe = 8'hFF;
      tick(2);
      bus_b.enable = 1'b1;
      tick(6);
      bus_b.enable = 1'b0;
      tick(6);
   endtask : b_nib

   task b_byte(input logic cs_n, input logic [7:0] v);
      bus_b.chip_select_n = cs_n;
      tick(2);
      for (int i = 7; i >= 0; i--) begin
         // Link clock of 124 ns, nearest 125 ns on the 4 ns grid
         bus_b.h_do[6] = v[i];
         tick(15);
         bus_b.h_do[7] = 1'b1;
         tick(16);
         bus_b.h_do[7] = 1'b0;
      end
      tick(4);
      bus_b.chip_select_n = 1'b1;
      tick(8);
   endtask : b_byte

   task sc_byte;
      reset_to(MODE_BYTE);
      cmd(1'b1, 1'b0, 8'hA5);
      cmd(1'b0, 1'b0, 8'h3C);
      rx_chk(0, 9'h1A5);
      rx_chk(0, 9'h03C);
      busy = 1'b1;
      addr_cnt = 7'h15;
      rd_chk(1'b0, 8'h95);
      rd_data = 8'h5A;
      rd_chk(1'b1, 8'h5A);
   endtask : sc_byte

   task sc_nibble;
      reset_to(MODE_NIBBLE);
      busy = 1'b0;
      cmd(1'b1, 1'b0, 8'hC3);
      rx_chk(0, 9'h1C3);
      busy = 1'b1;
      cmd_go(1'b0, 1'b0, 8'h81);
      tick(2000);
      chk("ready while busy", {8'h00, cmd_ready}, 9'h000);
      busy = 1'b0;
      wait_ready(20000);
      rx_chk(0, 9'h081);
      busy = 1'b1;
      addr_cnt = 7'h6B;
      rd_chk(1'b0, 8'hEB);
      rd_data = 8'hE7;
      rd_chk(1'b1, 8'hE7);
   endtask : sc_nibble

   task sc_serial;
      reset_to(MODE_SERIAL);
      cmd(1'b1, 1'b0, 8'h96);
      cmd(1'b0, 1'b0, 8'h21);
      cmd(1'b1, 1'b1, 8'h4D);
      rx_chk(0, 9'h196);
      rx_chk(0, 9'h021);
      rx_chk(0, 9'h14D);
   endtask : sc_serial

   task sc_i2c;
      reset_to(MODE_I2C);
      cmd(1'b1, 1'b0, 8'h7E);
      cmd(1'b0, 1'b0, 8'h08);
      rx_chk(0, 9'h17E);
      rx_chk(0, 9'h008);
   endtask : sc_i2c

   task sc_far_fault;
      reset_to(MODE_SERIAL);
      bus_b.h_oe = 8'hC0;
      b_byte(1'b1, 8'hFF);
      b_byte(1'b0, 8'hB4);
      rx_chk(1, 9'h1B4);
      chk("stray bytes", 9'(qb.size()), 9'h000);
      reset_to(MODE_NIBBLE);
      b_nib(8'hD5);
      b_nib(8'h2A);
      tick(8);
      rx_chk(1, 9'h1D2);
   endtask : sc_far_fault

   initial begin
      rst_b = 1'b0;
      mode = MODE_BYTE;
      cmd_valid = 1'b0;
      cmd_reg_sel = 1'b0;
      cmd_read = 1'b0;
      cmd_data = 8'h00;
      busy = 1'b0;
      addr_cnt = 7'h00;
      rd_data = 8'h00;
      bus_b.enable = 1'b0;
      bus_b.register_select = 1'b1;
      bus_b.read_sel = 1'b0;
      bus_b.chip_select_n = 1'b1;
      bus_b.h_do = 8'h00;
      bus_b.h_oe = 8'h00;
      sc_byte();
      sc_nibble();
      sc_serial();
      sc_i2c();
      sc_far_fault();
      wrap_up();
   end
endmodule : tb_lcd_controller_host_interface
